// ==== hdl/rxtsi_buf.sv ====
// two-entry valid/ready buffer between the inserter and the mac
`timescale 1ns/100ps
module rxtsi_buf
  import rxtsi_pkg::*;
#(
  parameter int W     = 10,  // word width
  parameter int DEPTH = 2    // entries
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // filling side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // draining side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];  // storage, drives data out from flops
  logic [AW-1:0] rd_ptr;      // oldest entry
  logic [AW-1:0] wr_ptr;      // next free entry
  logic [AW:0]   count;       // entries held
  logic          push;
  logic          pop;

  // honest flags: full stalls the filler, empty hides data
  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // pointer and count update, wrap at depth
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : rxtsi_buf

// ==== hdl/rxtsi_top.sv ====
// receive timestamp inserter: writes arrival time into event messages
`timescale 1ns/100ps
module rxtsi_top
  import rxtsi_pkg::*;
(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // apb slave
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [7:0]   paddr_in,
  input  wire logic [31:0]  pwdata_in,
  output logic [31:0]       prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  // receive link from the line side
  input  wire rxtsi_link_t  link_in,
  // byte stream towards the mac
  output logic              mac_valid_out,
  input  wire logic         mac_ready_in,
  output rxtsi_word_t       mac_word_out,
  // timestamp readout available
  output logic              ts_avail_out
);

  // whole module state
  typedef struct packed {
    rxtsi_link_t s1;        // first sync stage, read by s2 only
    rxtsi_link_t s2;        // second sync stage
    logic        clk_d;     // previous synced link clock
    logic        v_d;       // valid seen at previous link edge
    logic [11:0] ext_cfg;   // writable extended config bits
    logic [15:0] layout;    // insert layout register
    rxtsi_cfg_t  act;       // settings frozen for current frame
    logic        fr_ev;     // frame holds an event message
    logic        fr_v4;     // event message over ipv4
    logic        fr_l2;     // event message over layer 2
    logic        in_msg;    // inside or past the message
    logic        have_end;  // message end position known
    logic [11:0] pos;       // byte index from message start
    logic [11:0] end_pos;   // index of first byte after message
    logic [15:0] acc;       // ones complement checksum delta
    logic [63:0] ts_cap;    // timestamp for this frame
    logic        pend_v;    // byte held back one link edge
    rxtsi_word_t pend;      // held byte
    logic        out_v;     // byte waiting for the buffer
    rxtsi_word_t out;       // byte offered to the buffer
    logic        ts_ready;  // readout holds a fresh timestamp
    logic        ovf;       // byte lost to a mac stall
    logic [63:0] ts_hold;   // readout timestamp
    logic [31:0] prdata;    // registered read data
    logic        pslverr;   // registered error answer
  } rxtsi_st_t;

  rxtsi_st_t st;       // registered state
  rxtsi_st_t next_st;  // next state
  logic      buf_rdy;  // buffer can take a byte

  // ones complement add with end-around carry
  function automatic logic [15:0] oc_add(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc_add

  // place a byte in its word half by position parity
  function automatic logic [15:0] half(input logic [7:0] b,
                                       input logic odd);
    return odd ? {8'h00, b} : {b, 8'h00};
  endfunction : half

  // combinational read mux decode flag
  logic rd_hit;
  logic [31:0] rd_val;

  // register read values, reserved bits read zero
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr_in)
      RXTSI_EXT_CFG_ADDR: rd_val = {16'h0000, RXTSI_MIN_IFG_RST,
                                    st.ext_cfg};
      RXTSI_LAYOUT_ADDR:  rd_val = {16'h0000, st.layout};
      RXTSI_STATUS_ADDR:  rd_val = {30'h0000_0000, st.ovf, st.ts_ready};
      RXTSI_TS_LO_ADDR:   rd_val = st.ts_hold[31:0];
      RXTSI_TS_HI_ADDR:   rd_val = st.ts_hold[63:32];
      default:            rd_hit = 1'b0;
    endcase
  end

  // per-byte working values
  logic        ev;
  logic        start;
  logic        mod_ok;
  logic        udp_fix;
  logic        app;
  rxtsi_cfg_t  cfg;
  logic [11:0] p;
  logic        p_ok;
  logic [11:0] ns_pos;
  logic [11:0] sec_pos;
  logic [11:0] sec_n;
  logic [11:0] k;
  logic [7:0]  b;
  logic [15:0] corr;
  logic        rep;

  // next state
  always_comb begin
    next_st = st;
    // two-flop synchroniser for every link pin
    next_st.s1 = link_in;
    next_st.s2 = st.s1;
    next_st.clk_d = st.s2.clk;
    ev = st.s2.clk && !st.clk_d;
    start = ev && st.s2.valid && !st.v_d;
    // frame settings: freeze at frame start
    cfg.insert  = st.ext_cfg[RXTSI_INSERT_BIT];
    cfg.append  = st.ext_cfg[RXTSI_APPEND_BIT];
    cfg.udp_mod = st.layout[RXTSI_UDP_MOD_BIT];
    cfg.sec_en  = st.layout[RXTSI_SEC_EN_BIT];
    cfg.sec_len = st.layout[RXTSI_SEC_LEN_LSB +: 2];
    cfg.ns_off  = st.layout[RXTSI_NS_OFF_LSB +: 6];
    cfg.sec_off = st.layout[RXTSI_SEC_OFF_LSB +: 6];
    if (!start) begin
      cfg = st.act;  // mid-frame writes wait for the next frame
    end
    // byte position from message start
    p    = st.s2.msg_start ? 12'h000 : st.pos + 12'h001;
    p_ok = st.s2.msg_start || st.in_msg;
    mod_ok  = cfg.insert && (st.s2.msg_start ? st.s2.ptp_event
                                             : st.fr_ev);
    udp_fix = mod_ok && cfg.udp_mod &&
              (st.s2.msg_start ? st.s2.ipv4 : st.fr_v4);
    app = cfg.append &&
          (st.s2.msg_start ? st.s2.layer2 : st.fr_l2);
    // field positions, append counts from message end
    ns_pos  = app ? st.end_pos + 12'(cfg.ns_off) : 12'(cfg.ns_off);
    sec_pos = app ? ns_pos + RXTSI_NS_BYTES + 12'(cfg.sec_off)
                  : 12'(cfg.sec_off);
    sec_n   = 12'(cfg.sec_len) + 12'h001;  // 00 one byte .. 11 four
    b    = st.s2.data;
    rep  = 1'b0;
    k    = 12'h000;
    corr = 16'h0000;
    if (ev) begin
      // release the held byte; last when the frame has just ended
      if (st.pend_v) begin
        next_st.out = st.pend;
        next_st.out.last = !st.s2.valid;
        next_st.out.crc_err = !st.s2.valid && mod_ok && st.fr_v4 &&
                              !cfg.udp_mod && st.s2.udp_err;
        next_st.out_v = 1'b1;
        next_st.pend_v = 1'b0;
        if (st.out_v) begin
          next_st.ovf = 1'b1;  // mac stalled past one byte time
        end
      end
      if (st.s2.valid) begin
        if (start) begin
          next_st.act = cfg;
          next_st.in_msg = 1'b0;
          next_st.have_end = 1'b0;
          next_st.fr_ev = 1'b0;
          next_st.acc = 16'h0000;
          next_st.ts_cap = st.s2.ts;
        end
        if (st.s2.msg_start) begin
          next_st.in_msg = 1'b1;
          next_st.fr_ev = st.s2.ptp_event;
          next_st.fr_v4 = st.s2.ipv4;
          next_st.fr_l2 = st.s2.layer2;
          next_st.have_end = 1'b0;
          next_st.acc = 16'h0000;
        end
        if (p_ok) begin
          next_st.pos = p;
        end
        if (p_ok && st.s2.msg_end) begin
          next_st.have_end = 1'b1;
          next_st.end_pos = p + 12'h001;
        end
        if (p_ok && mod_ok && (!app || st.have_end)) begin
          // nanoseconds field, big endian
          if (p >= ns_pos && p < ns_pos + RXTSI_NS_BYTES) begin
            k = RXTSI_NS_BYTES - 12'h001 - (p - ns_pos);
            b = 8'(st.ts_cap[31:0] >> {k[1:0], 3'b000});
            rep = 1'b1;
          end
          // low-order seconds bytes only when enabled
          if (cfg.sec_en && p >= sec_pos && p < sec_pos + sec_n) begin
            k = sec_n - 12'h001 - (p - sec_pos);
            b = 8'(st.ts_cap[63:32] >> {k[1:0], 3'b000});
            rep = 1'b1;
          end
        end
        // mode 0: sum bytes precede the message, so use live class
        if (cfg.insert && st.s2.ptp_event && st.s2.ipv4 && !cfg.udp_mod &&
            st.s2.csum_byte && !st.s2.msg_start) begin
          b = 8'h00;
        end
        // fold each replaced byte into the checksum delta
        if (rep && udp_fix) begin
          next_st.acc = oc_add(oc_add(st.acc, half(st.s2.data, p[0])),
                               ~half(b, p[0]));
        end
        // spare bytes after the message carry the correction
        if (udp_fix && st.have_end && p_ok &&
            p == st.end_pos + 12'h001) begin
          corr = oc_add(st.acc, {st.pend.data, st.s2.data});
          if (st.s2.udp_err) begin
            corr = corr ^ 16'h0001;  // incoming error stays visible
          end
          next_st.out.data = corr[15:8];
          b = corr[7:0];
        end
        next_st.pend.data = b;
        next_st.pend.last = 1'b0;
        next_st.pend.crc_err = 1'b0;
        next_st.pend_v = 1'b1;
      end else if (st.v_d) begin
        // frame over: readout only if nothing was inserted
        next_st.in_msg = 1'b0;
        if (st.fr_ev && !st.act.insert) begin
          next_st.ts_ready = 1'b1;
          next_st.ts_hold = st.ts_cap;
        end
      end
      next_st.v_d = st.s2.valid;
    end
    // hand the byte to the buffer once it has room
    if (st.out_v && buf_rdy && !(ev && st.pend_v)) begin
      next_st.out_v = 1'b0;
    end
    // apb: read data and error caught in the setup phase
    if (psel_in && !penable_in) begin
      next_st.prdata = pwrite_in ? 32'h0000_0000 : rd_val;
      next_st.pslverr = !rd_hit;
    end
    // apb: writes take effect in the access phase
    if (psel_in && penable_in && pwrite_in) begin
      case (paddr_in)
        RXTSI_EXT_CFG_ADDR: next_st.ext_cfg = pwdata_in[11:0];
        RXTSI_LAYOUT_ADDR:  next_st.layout = pwdata_in[15:0];
        RXTSI_STATUS_ADDR: begin
          // write one to clear; a set that raises the flag in the same cycle wins
          if (pwdata_in[RXTSI_TS_READY_BIT] && !(next_st.ts_ready &&
              !st.ts_ready)) begin
            next_st.ts_ready = 1'b0;
          end
          if (pwdata_in[RXTSI_OVERFLOW_BIT] && !(next_st.ovf &&
              !st.ovf)) begin
            next_st.ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.ext_cfg <= RXTSI_EXT_CFG_RST;
      st.layout <= RXTSI_LAYOUT_RST;
    end else begin
      st <= next_st;
    end
  end

  // two-entry buffer absorbs short mac stalls
  rxtsi_buf #(
    .W     ($bits(rxtsi_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (st.out_v),
    .in_ready_out  (buf_rdy),
    .in_data_in    (st.out),
    .out_valid_out (mac_valid_out),
    .out_ready_in  (mac_ready_in),
    .out_data_out  (mac_word_out)
  );

  // apb answers without wait states
  assign pready_out   = 1'b1;
  assign prdata_out   = st.prdata;
  assign pslverr_out  = st.pslverr;
  assign ts_avail_out = st.ts_ready;

endmodule : rxtsi_top

// ==== include/rxtsi_pkg.sv ====
// package: register map, field positions and carriers of the rx timestamp inserter
package rxtsi_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] RXTSI_EXT_CFG_ADDR = 8'h1C;
  localparam logic [7:0] RXTSI_LAYOUT_ADDR  = 8'h20;
  localparam logic [7:0] RXTSI_STATUS_ADDR  = 8'h24;
  localparam logic [7:0] RXTSI_TS_LO_ADDR   = 8'h28;
  localparam logic [7:0] RXTSI_TS_HI_ADDR   = 8'h2C;

  // extended config fields
  localparam int         RXTSI_INSERT_BIT   = 8;
  localparam int         RXTSI_APPEND_BIT   = 9;
  localparam logic [3:0] RXTSI_MIN_IFG_RST  = 4'hC;
  localparam logic [11:0] RXTSI_EXT_CFG_RST = 12'h000;

  // insert layout fields
  localparam int          RXTSI_UDP_MOD_BIT = 15;
  localparam int          RXTSI_SEC_EN_BIT  = 14;
  localparam int          RXTSI_SEC_LEN_LSB = 12;
  localparam int          RXTSI_NS_OFF_LSB  = 6;
  localparam int          RXTSI_SEC_OFF_LSB = 0;
  localparam logic [15:0] RXTSI_LAYOUT_RST  = 16'h0000;

  // status fields
  localparam int RXTSI_TS_READY_BIT = 0;
  localparam int RXTSI_OVERFLOW_BIT = 1;

  // nanoseconds field length in bytes
  localparam logic [11:0] RXTSI_NS_BYTES = 12'h004;

  // receive byte stream plus parser sideband, as it arrives on pins
  typedef struct packed {
    logic        clk;        // link byte clock
    logic        valid;      // frame data valid
    logic [7:0]  data;       // received byte
    logic        msg_start;  // first byte of the time message
    logic        msg_end;    // last byte of the time message
    logic        csum_byte;  // byte belongs to the udp checksum
    logic        ptp_event;  // frame holds an event message
    logic        ipv4;       // message is udp over ipv4
    logic        layer2;     // message is layer 2 encapsulated
    logic        udp_err;    // incoming udp checksum is bad
    logic [63:0] ts;         // captured arrival time, sec:ns
  } rxtsi_link_t;

  // one byte towards the mac
  typedef struct packed {
    logic [7:0] data;     // byte
    logic       last;     // last byte of frame
    logic       crc_err;  // force a frame crc error
  } rxtsi_word_t;

  // insertion settings held for one frame
  typedef struct packed {
    logic       insert;
    logic       append;
    logic       udp_mod;
    logic       sec_en;
    logic [1:0] sec_len;
    logic [5:0] ns_off;
    logic [5:0] sec_off;
  } rxtsi_cfg_t;

endpackage : rxtsi_pkg

// ==== tb/rxtsi_mac_model.sv ====
// behavioural mac: accepts bytes from the inserter, stalls when told
`timescale 1ns/100ps
module rxtsi_mac_model
  import rxtsi_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // stall style: 0 prompt, 1 random stalls, 2 frozen
  input  wire logic [1:0]  mode_in,
  // stream from the inserter
  input  wire logic        valid_in,
  output logic             ready_out,
  input  wire rxtsi_word_t word_in
);
  rxtsi_word_t got[$];          // accepted words in order
  integer      seed = 32'h58B26771; // fixed stream for stalls
  logic [31:0] r;               // random draw
  // a word counts at the edge where valid and ready are both high;
  // ready moves only after that edge, so no handshake is half-seen
  always @(posedge clk_in) begin
    if (!rst_in && valid_in && ready_out)
      got.push_back(word_in);
    r = $random(seed);
    ready_out <= !rst_in && (mode_in == 2'h0 || (mode_in == 2'h1 && r[0]));
  end
endmodule : rxtsi_mac_model

// ==== tb/rxtsi_properties.sv ====
// checker: port-level properties of the rx timestamp inserter
`timescale 1ns/100ps
module rxtsi_properties
  import rxtsi_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // apb slave side
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // link and mac side
  input wire rxtsi_link_t link_in,
  input wire logic        mac_valid_out,
  input wire logic        mac_ready_in,
  input wire rxtsi_word_t mac_word_out,
  input wire logic        ts_avail_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic ins_q;   // insert enable as last written over apb
  logic mapped;  // address hits one of the five registers
  assign mapped = paddr_in inside {RXTSI_EXT_CFG_ADDR, RXTSI_LAYOUT_ADDR,
    RXTSI_STATUS_ADDR, RXTSI_TS_LO_ADDR, RXTSI_TS_HI_ADDR};
  // shadow of the insert bit; only valid while settings change between frames
  always_ff @(posedge clk_in) begin
    if (rst_in)
      ins_q <= 1'b0;
    else if (psel_in && penable_in && pwrite_in &&
             paddr_in == RXTSI_EXT_CFG_ADDR)
      ins_q <= pwdata_in[RXTSI_INSERT_BIT];
  end
  sequence setup_s;  // first cycle of an apb transfer
    psel_in && !penable_in;
  endsequence
  sequence cfg_read_s;  // read aimed at the extended config
    setup_s ##0 (!pwrite_in && paddr_in == RXTSI_EXT_CFG_ADDR);
  endsequence
  pready_high_a: assert property (pready_out)
    else $error("pready low");
  unmapped_err_a: assert property (setup_s ##0 (!mapped && !pwrite_in) |=>
    pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr_out)
    else $error("mapped access refused");
  ifg_ro_a: assert property (cfg_read_s |=>
    prdata_out[15:12] == RXTSI_MIN_IFG_RST) else $error("gap field wrong");
  upper_zero_a: assert property (cfg_read_s |=> prdata_out[31:16] == 16'h0)
    else $error("upper half not zero");
  word_hold_a: assert property (mac_valid_out && !mac_ready_in |=>
    mac_valid_out && $stable(mac_word_out)) else $error("word lost in stall");
  quiet_start_a: assert property ($fell(rst_in) |-> !mac_valid_out [*3])
    else $error("output before any frame");
  no_readout_a: assert property ($rose(ts_avail_out) |-> !ins_q)
    else $error("readout while inserting");
endmodule : rxtsi_properties

bind rxtsi_top rxtsi_properties u_props (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .link_in(link_in),
  .mac_valid_out(mac_valid_out), .mac_ready_in(mac_ready_in),
  .mac_word_out(mac_word_out), .ts_avail_out(ts_avail_out)
);

// ==== tb/testbench.sv ====
// testbench: register access, framed inserts and stalls of the inserter
`timescale 1ns/100ps
module testbench
  import rxtsi_pkg::*;
;
  localparam int FLEN = 48;  // bytes per frame
  localparam int MS   = 6;   // first message byte
  localparam int CS   = 2;   // first udp checksum byte
  logic        clk_in, rst_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, er, mac_valid_out, mac_ready_in;
  logic        ts_avail_out;
  rxtsi_link_t link_in;          // line side pins
  rxtsi_word_t mac_word_out;     // word towards the mac
  logic [1:0]  mac_mode;         // stall style of the mac model
  integer      seed = 32'h58B26771;
  logic [31:0] r;                // random draw
  logic [7:0]  fdat [FLEN];      // frame bytes as sent
  logic [63:0] tsv;              // arrival time as sent
  logic [15:0] lw;               // layout word of the next frame
  int          err_total = 0;
  int          cmp_count = 0;

  rxtsi_top uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .link_in(link_in),
    .mac_valid_out(mac_valid_out), .mac_ready_in(mac_ready_in),
    .mac_word_out(mac_word_out), .ts_avail_out(ts_avail_out));
  rxtsi_mac_model mac (.clk_in(clk_in), .rst_in(rst_in), .mode_in(mac_mode),
    .valid_in(mac_valid_out), .ready_out(mac_ready_in),
    .word_in(mac_word_out));

  // 10 mhz system clock
  always #50 clk_in = ~clk_in;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // hang guard, well past the few hundred microseconds the run needs
  initial begin
    #3000000;
    err_total++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end

  task automatic check(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // one apb transfer; held until pready is seen high, wait not bounded
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d,
                     output logic e);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1);
    d = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    check("apb access cycles", 32'h1, n);  // no wait states expected
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
    logic [31:0] d;
    logic        x;
    apb(1'b0, a, 32'h0, d, x);
    check("read data", e, d);
    check("slverr", {31'h0, ee}, {31'h0, x});
  endtask : rdchk

  // ones complement add with end-around carry, for expected sums
  function automatic logic [15:0] oc_sum(logic [15:0] a, logic [15:0] c);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, c};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc_sum

  // expected word at byte i for one frame's settings; layer 2 frames
  // always run in append mode, their fields start after the message
  function automatic rxtsi_word_t exp_word(int i, logic [15:0] lay,
                                           logic ins, logic ue, logic l2);
    rxtsi_word_t w;
    int ns, so, nb;
    w = {fdat[i], i == FLEN - 1, 1'b0};
    ns = (l2 ? FLEN - 2 : MS) + int'(lay[11:6]);
    so = l2 ? ns + 4 + int'(lay[5:0]) : MS + int'(lay[5:0]);
    nb = int'(lay[13:12]) + 1;
    if (ins) begin
      if (i >= ns && i < ns + 4) w.data = tsv[8*(ns+3-i) +: 8];
      if (lay[14] && i >= so && i < so + nb)  // seconds win on overlap
        w.data = tsv[32+8*(so+nb-1-i) +: 8];
      if (!l2 && !lay[15] && (i == CS || i == CS + 1))
        w.data = 8'h00;  // mode 0 clears the ipv4 sum
      w.crc_err = ue && w.last && !l2 && !lay[15];
    end
    return w;
  endfunction : exp_word

  // one frame, bytes change with the falling link edge, clock stops after
  task automatic send(input logic ue, input logic l2);
    link_in.ts <= tsv;
    link_in.udp_err <= ue;
    link_in.ptp_event <= 1'b1;
    link_in.ipv4 <= !l2;
    link_in.layer2 <= l2;
    for (int i = 0; i < FLEN + 3; i++) begin
      link_in.clk <= 1'b0;
      link_in.valid <= i < FLEN;
      link_in.data <= (i < FLEN) ? fdat[i] : ~link_in.data;
      link_in.msg_start <= i == MS;
      link_in.msg_end <= i == FLEN - 3;
      link_in.csum_byte <= i == CS || i == CS + 1;
      repeat (4) @(posedge clk_in);
      link_in.clk <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    link_in.clk <= 1'b0;
  endtask : send

  task automatic run_frame(input logic ins, input logic [15:0] lay,
                           input logic ue, input logic l2);
    int          n;
    rxtsi_word_t ex [FLEN];  // expected words of the frame
    logic [15:0] s_old;      // udp sum of the bytes as sent
    logic [15:0] s_new;      // udp sum of the bytes as rewritten
    logic [15:0] cr;         // correction that keeps the sum
    r = $random(seed);
    mac_mode <= {1'b0, r[1]};
    apb(1'b1, RXTSI_LAYOUT_ADDR, {16'h0, lay}, rd, er);
    apb(1'b1, RXTSI_EXT_CFG_ADDR, {22'h0, r[0] | l2, ins, 8'h00}, rd, er);
    tsv = {$random(seed), $random(seed)};
    foreach (fdat[i]) fdat[i] = 8'($random(seed));
    s_old = 16'h0000;
    s_new = 16'h0000;
    // even bytes are the high half of each sixteen-bit word
    for (int i = 0; i < FLEN; i++) begin
      ex[i] = exp_word(i, lay, ins, ue, l2);
      s_old = oc_sum(s_old, {fdat[i], 8'h00} >> (i[0] ? 8 : 0));
      if (i < FLEN - 2)
        s_new = oc_sum(s_new, {ex[i].data, 8'h00} >> (i[0] ? 8 : 0));
    end
    // the two spare bytes after the message keep the whole sum, and a
    // bad incoming sum has to stay bad
    cr = oc_sum(s_old, ~s_new) ^ {15'h0000, ue};
    if (ins && lay[15] && !l2) begin
      ex[FLEN-2].data = cr[15:8];
      ex[FLEN-1].data = cr[7:0];
    end
    mac.got.delete();
    send(ue, l2);
    n = 0;
    while (mac.got.size() < FLEN && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    check("frame length", FLEN, mac.got.size());
    for (int i = 0; i < FLEN; i++)
      check("mac word", {22'h0, ex[i]}, {22'h0, mac.got[i]});
    check("ts avail", {31'h0, !ins}, {31'h0, ts_avail_out});
    if (!ins) begin
      rdchk(RXTSI_TS_LO_ADDR, tsv[31:0], 1'b0);
      rdchk(RXTSI_TS_HI_ADDR, tsv[63:32], 1'b0);
      apb(1'b1, RXTSI_STATUS_ADDR, 32'h1, rd, er);
    end
  endtask : run_frame

  // main sequence: registers, frames, then a frozen mac
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    link_in = '0;
    mac_mode = 2'h0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(RXTSI_EXT_CFG_ADDR, 32'h0000C000, 1'b0);
    rdchk(RXTSI_LAYOUT_ADDR, 32'h0, 1'b0);
    rdchk(8'h40, 32'h0, 1'b1);
    apb(1'b1, RXTSI_EXT_CFG_ADDR, 32'hFFFFFFFF, rd, er);
    rdchk(RXTSI_EXT_CFG_ADDR, 32'h0000CFFF, 1'b0);
    run_frame(1'b0, 16'hFFFF, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      lw = {2'h1, 2'(k), 1'b0, r[4:0], 1'b0, r[12:8]};
      run_frame(1'b1, lw, 1'(k), 1'b0);
    end
    run_frame(1'b1, 16'h3900, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      lw = {2'h0, r[14:12], r[4:0], 1'b0, r[12:8]};
      run_frame(1'b1, lw, r[20], 1'b0);
    end
    // correction mode: frames carry two spare bytes, seconds enabled
    for (int k = 0; k < 2; k++) begin
      r = $random(seed);
      lw = {2'h3, r[13:12], 1'b0, r[4:0], 1'b0, r[12:8]};
      run_frame(1'b1, lw, 1'(k), 1'b0);
    end
    // layer 2 frames: appended after the message, no ipv4 handling
    for (int k = 0; k < 2; k++)
      run_frame(1'b1, 16'h7000 | 16'(k << 6), 1'b1, 1'b1);
    mac_mode <= 2'h2;
    send(1'b0, 1'b0);
    apb(1'b0, RXTSI_STATUS_ADDR, 32'h0, rd, er);
    check("overflow", 32'h2, rd & 32'h2);
    mac_mode <= 2'h0;
    apb(1'b1, RXTSI_STATUS_ADDR, 32'h3, rd, er);
    rdchk(RXTSI_STATUS_ADDR, 32'h0, 1'b0);
    wrap_up();
  end
endmodule : testbench
